/* File: nip_top.sv */
// interrupt intake: line latching, pending/active state, arbitration
// assumes core strobes entry/exit for one cycle and never both at once
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module nip_top #(
	parameter int NUM_IRQ = nip_pkg::NUM_IRQ
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [NUM_IRQ-1:0] irq_i,
	input wire logic nmi_i,
	input wire nip_pkg::nip_bus_t bus_i,
	input wire nip_pkg::nip_core_t core_i,
	output logic [31:0] rdata_o,
	output logic irq_req_o,
	output logic [4:0] irq_id_o,
	output logic [2:0] irq_prio_o,
	output logic nmi_req_o,
	output logic stack_save_o,
	output logic stack_restore_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	logic [NUM_IRQ-1:0] sync1, line_s, line_d;
	logic [2:0] nmi_sh;
	logic [NUM_IRQ-1:0] en, mode, pend, act;
	logic [NUM_IRQ-1:0] next_en, next_mode, next_pend, next_act;
	logic [2:0] prio [NUM_IRQ];
	logic [2:0] next_prio [NUM_IRQ];
	logic [1:0] split, next_split;
	logic nmi_pend, next_nmi_pend;
	logic [31:0] next_rdata;
	logic next_req;
	logic [NUM_IRQ-1:0] rise, sw_set, sw_clr, ent, ext, elig;
	logic [4:0] best_id;
	logic [3:0] best_p, run_p;
	logic found;
	logic prio_hit;
	logic [1:0] prio_idx;
	logic [NUM_IRQ-1:0] hold_rise;

	// two flops before any logic; sync1 feeds only line_s
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync1 <= '0;
			line_s <= '0;
			line_d <= '0;
			nmi_sh <= 3'h0;
		end else begin
			sync1 <= irq_i;
			line_s <= sync1;
			line_d <= line_s;
			nmi_sh <= {nmi_sh[1:0], nmi_i};
		end
	end

	// a one-cycle pulse survives the synchroniser since every edge samples
	assign rise = line_s & ~line_d;

	// bus strobes decoded per line
	always_comb begin
		sw_set = '0;
		sw_clr = '0;
		if (bus_i.we && bus_i.addr == nip_pkg::OFS_SETPEND)
			sw_set = bus_i.wdata[NUM_IRQ-1:0];
		if (bus_i.we && bus_i.addr == nip_pkg::OFS_SOFT_TRIG)
			sw_set[bus_i.wdata[4:0]] = 1'b1;
		if (bus_i.we && bus_i.addr == nip_pkg::OFS_CLRPEND)
			sw_clr = bus_i.wdata[NUM_IRQ-1:0];
	end

	// per-line state; any set term wins over clear, and all but the level term win over entry
	genvar g;
	generate
		for (g = 0; g < NUM_IRQ; g++) begin : gl
			logic hw_set;
			assign ent[g] = core_i.entry && core_i.id == 5'(g);
			assign ext[g] = core_i.exit && core_i.id == 5'(g);
			// level: high and not active; pulse: rising edge
			assign hw_set = mode[g] ? rise[g]
				: (line_s[g] && !act[g] && !ent[g]);
			assign next_act[g] = ent[g] ? 1'b1
				: (ext[g] ? 1'b0 : act[g]);
			assign next_pend[g] = hw_set || sw_set[g] ? 1'b1
				: ent[g] ? 1'b0
				: (ext[g] && !mode[g]) ? line_s[g]
				: (sw_clr[g] && mode[g]) ? 1'b0
				: (sw_clr[g] && !line_s[g]) ? 1'b0
				: pend[g];
			assign elig[g] = pend[g] && en[g] && !act[g];
		end
	endgenerate

	// pulse lines pulsed again while their routine runs
	assign hold_rise = mode & act & rise & ~ent & ~ext;

	assign prio_hit = bus_i.addr >= nip_pkg::OFS_PRIO0 &&
		bus_i.addr < nip_pkg::OFS_SPLIT;
	assign prio_idx = 2'((bus_i.addr - nip_pkg::OFS_PRIO0) >> 2);

	// configuration writes; priorities change at any time
	always_comb begin
		next_en = en;
		next_mode = mode;
		next_split = split;
		next_prio = prio;
		if (bus_i.we) begin
			case (bus_i.addr)
				nip_pkg::OFS_ENABLE: next_en = bus_i.wdata[NUM_IRQ-1:0];
				nip_pkg::OFS_MODE: next_mode = bus_i.wdata[NUM_IRQ-1:0];
				nip_pkg::OFS_SPLIT: next_split = bus_i.wdata[1:0];
				default: ;
			endcase
			if (prio_hit)
				for (int j = 0; j < nip_pkg::PRIO_PER_REG; j++)
					if (prio_idx * 8 + j < NUM_IRQ)
						next_prio[prio_idx * 8 + j] =
							bus_i.wdata[j * nip_pkg::PRIO_FLD +: 3];
		end
	end

	// arbitration: scan downward with <= so lowest number keeps ties
	always_comb begin
		best_id = 5'h0;
		best_p = nip_pkg::PRIO_NONE;
		run_p = nip_pkg::PRIO_NONE;
		found = 1'b0;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (elig[i] && {1'b0, prio[i]} <= best_p) begin
				best_p = {1'b0, prio[i]};
				best_id = 5'(i);
				found = 1'b1;
			end
			if (act[i] && {1'b0, prio[i]} < run_p)
				run_p = {1'b0, prio[i]};
		end
		// only the group part preempts; subpriority just orders
		next_req = found && ((best_p >> split) < (run_p >> split));
	end

	// nmi: edge latched, cleared by its own entry, no mask applies
	always_comb begin
		next_nmi_pend = nmi_pend;
		if (core_i.nmi_entry)
			next_nmi_pend = 1'b0;
		if (nmi_sh[1] && !nmi_sh[2])
			next_nmi_pend = 1'b1;
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 32'h0;
		if (bus_i.re) begin
			case (bus_i.addr)
				nip_pkg::OFS_ENABLE: next_rdata = 32'(en);
				nip_pkg::OFS_SETPEND: next_rdata = 32'(pend);
				nip_pkg::OFS_CLRPEND: next_rdata = 32'(pend);
				nip_pkg::OFS_ACTIVE: next_rdata = 32'(act);
				nip_pkg::OFS_MODE: next_rdata = 32'(mode);
				nip_pkg::OFS_SPLIT: next_rdata = {30'h0, split};
				nip_pkg::OFS_STATUS: begin
					next_rdata[nip_pkg::STAT_ID_LSB +: 5] = best_id;
					next_rdata[nip_pkg::STAT_PRIO_LSB +: 3] = best_p[2:0];
					next_rdata[nip_pkg::STAT_VALID_BIT] = found;
					next_rdata[nip_pkg::STAT_NMI_BIT] = nmi_pend;
				end
				default: ;
			endcase
			if (prio_hit)
				for (int j = 0; j < nip_pkg::PRIO_PER_REG; j++)
					if (prio_idx * 8 + j < NUM_IRQ)
						next_rdata[j * nip_pkg::PRIO_FLD +: 3] =
							prio[prio_idx * 8 + j];
		end
	end

	// state and outputs registered
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			en <= nip_pkg::RST_ENABLE[NUM_IRQ-1:0];
			mode <= nip_pkg::RST_MODE[NUM_IRQ-1:0];
			pend <= '0;
			act <= '0;
			split <= nip_pkg::RST_SPLIT;
			for (int i = 0; i < NUM_IRQ; i++)
				prio[i] <= nip_pkg::RST_PRIO;
			nmi_pend <= 1'b0;
			rdata_o <= 32'h0;
			irq_req_o <= 1'b0;
			irq_id_o <= 5'h0;
			irq_prio_o <= 3'h0;
			nmi_req_o <= 1'b0;
			stack_save_o <= 1'b0;
			stack_restore_o <= 1'b0;
		end else begin
			en <= next_en;
			mode <= next_mode;
			pend <= next_pend;
			act <= next_act;
			split <= next_split;
			prio <= next_prio;
			nmi_pend <= next_nmi_pend;
			rdata_o <= next_rdata;
			irq_req_o <= next_req;
			irq_id_o <= best_id;
			irq_prio_o <= best_p[2:0];
			nmi_req_o <= next_nmi_pend;
			// core does the stacking; these just tell it when
			stack_save_o <= core_i.entry || core_i.nmi_entry;
			stack_restore_o <= core_i.exit;
		end
	end

	sequence pulse_rise_s;
		mode[0] && rise[0];
	endsequence
	sequence quiet0_s;
		!rise[0] && !sw_set[0] && !bus_i.we;
	endsequence

	prio_store_a: assert property (
		bus_i.we && bus_i.addr == nip_pkg::OFS_PRIO0 |=>
		prio[0] == $past(bus_i.wdata[2:0]))
		else $error("priority write lost");
	prio_order_a: assert property (
		elig[0] |-> found && best_p <= {1'b0, prio[0]})
		else $error("more urgent line passed over");
	tie_low_a: assert property (
		elig[0] && best_p == {1'b0, prio[0]} |-> best_id == 5'h0)
		else $error("tie not won by lowest number");
	level_pend_a: assert property (
		!mode[0] && line_s[0] && !act[0] && !core_i.entry |=> pend[0])
		else $error("level line not pending");
	pulse_edge_a: assert property (
		pulse_rise_s |=> pend[0])
		else $error("pulse edge not latched");
	soft_trig_a: assert property (
		bus_i.we && bus_i.addr == nip_pkg::OFS_SOFT_TRIG &&
		bus_i.wdata[4:0] == 5'h0 |=> pend[0])
		else $error("soft trigger lost");
	entry_act_a: assert property (
		ent[0] && mode[0] and quiet0_s |=> act[0] && !pend[0])
		else $error("entry did not activate");
	exit_level_a: assert property (
		ext[0] && !mode[0] and quiet0_s |=>
		!act[0] && pend[0] == $past(line_s[0]))
		else $error("level exit wrong");
	exit_pulse_a: assert property (
		ext[0] && mode[0] and quiet0_s |=>
		!act[0] && pend[0] == $past(pend[0]))
		else $error("pulse exit wrong");
	clr_level_a: assert property (
		!mode[0] && sw_clr[0] && !ext[0] && !ent[0] && !sw_set[0] |=>
		pend[0] == ($past(line_s[0]) &&
		($past(pend[0]) || !$past(act[0]))))
		else $error("level clear wrong");
	clr_pulse_a: assert property (
		mode[0] && sw_clr[0] && !rise[0] && !ent[0] && !ext[0] |=>
		!pend[0] && act[0] == $past(act[0]))
		else $error("pulse clear wrong");
	nmi_path_a: assert property (
		nmi_sh[1] && !nmi_sh[2] |=> nmi_pend ##0 nmi_req_o)
		else $error("nmi not raised");
	stack_a: assert property (
		core_i.entry |=> stack_save_o ##1 !stack_save_o ||
		$past(core_i.entry) || $past(core_i.nmi_entry))
		else $error("stack save not signalled");
	group_a: assert property (
		found && act == '0 |=> irq_req_o)
		else $error("idle core not requested");

	// register stores, strobe outputs and vector-wide state moves
	setpend_a: assert property (
		bus_i.we && bus_i.addr == nip_pkg::OFS_SETPEND |=>
		(pend & $past(sw_set)) == $past(sw_set))
		else $error("set-pending write lost");
	pend_keep_a: assert property (
		pend[0] && !ent[0] && !ext[0] && !sw_clr[0] |=> pend[0])
		else $error("pending dropped without cause");
	pulse_again_a: assert property (
		hold_rise != '0 |=>
		(pend & act & $past(hold_rise)) == $past(hold_rise))
		else $error("pulse in service not kept");
	mode_store_a: assert property (
		bus_i.we && bus_i.addr == nip_pkg::OFS_MODE |=>
		mode == $past(bus_i.wdata[NUM_IRQ-1:0]))
		else $error("mode write lost");
	split_store_a: assert property (
		bus_i.we && bus_i.addr == nip_pkg::OFS_SPLIT |=>
		split == $past(bus_i.wdata[1:0]))
		else $error("split write lost");
	restore_a: assert property (
		core_i.exit |=> stack_restore_o)
		else $error("stack restore not signalled");
	nmi_clear_a: assert property (
		core_i.nmi_entry && !(nmi_sh[1] && !nmi_sh[2]) |=> !nmi_req_o)
		else $error("nmi not cleared by entry");
	rdata_idle_a: assert property (
		!bus_i.re |=> rdata_o == 32'h0)
		else $error("read data outside read slot");
endmodule
`default_nettype wire

/* File: nip_pkg.sv */
// constants, register map and carrier types of the interrupt intake logic
// assumes one 10 MHz clock and a simple strobe register port
package nip_pkg;
	localparam int NUM_IRQ = 32;
	localparam int PRIO_W = 3;
	localparam int ID_W = 5;
	localparam int PRIO_FLD = 4;
	localparam int PRIO_PER_REG = 8;
	localparam int PRIO_REGS = 4;
	// register offsets
	localparam logic [7:0] OFS_ENABLE = 8'h00;
	localparam logic [7:0] OFS_SETPEND = 8'h04;
	localparam logic [7:0] OFS_CLRPEND = 8'h08;
	localparam logic [7:0] OFS_ACTIVE = 8'h0c;
	localparam logic [7:0] OFS_MODE = 8'h10;
	localparam logic [7:0] OFS_SOFT_TRIG = 8'h14;
	localparam logic [7:0] OFS_PRIO0 = 8'h18;
	localparam logic [7:0] OFS_SPLIT = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2c;
	// field positions of the status word
	localparam int STAT_ID_LSB = 0;
	localparam int STAT_PRIO_LSB = 5;
	localparam int STAT_VALID_BIT = 8;
	localparam int STAT_NMI_BIT = 9;
	// reset values
	localparam logic [31:0] RST_ENABLE = 32'h0;
	localparam logic [31:0] RST_MODE = 32'h0;
	localparam logic [2:0] RST_PRIO = 3'h0;
	localparam logic [1:0] RST_SPLIT = 2'h0;
	localparam logic [3:0] PRIO_NONE = 4'h8;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic we;
		logic re;
	} nip_bus_t;

	typedef struct packed {
		logic entry;
		logic exit;
		logic [4:0] id;
		logic nmi_entry;
	} nip_core_t;
endpackage

/* File: nip_src.sv */
// peripheral side model: drives the 32 request lines of the sources
// assumes the bench calls its tasks from the clock domain of ref_clk_i
`timescale 1ns/100ps
`default_nettype none
module nip_src (
	input wire logic ref_clk_i,
	output var logic [31:0] irq_o
);
	initial irq_o = 32'h0;
	// one full cycle high, so the sampler cannot miss it
	task automatic pulse(input int id);
		@(posedge ref_clk_i) irq_o[id] <= 1'b1;
		@(posedge ref_clk_i) irq_o[id] <= 1'b0;
	endtask
	// level source keeps the line up until told its cause is gone
	task automatic hold(input int id, input logic v);
		@(posedge ref_clk_i) irq_o[id] <= v;
	endtask
endmodule
`default_nettype wire

/* File: tb_nested_irq_pending_logic.sv */
// self-checking bench of the interrupt intake logic
// assumes the register map and core strobes of nip_pkg
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_nested_irq_pending_logic;
	typedef struct packed {
		logic [4:0] id;
		logic md;
		logic [1:0] src;
		logic ex;
	} nip_row_t;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic nmi_i = 1'b0;
	logic [31:0] irq;
	nip_pkg::nip_bus_t bus = '0;
	nip_pkg::nip_core_t core = '0;
	logic [31:0] rdata_o;
	logic irq_req_o, nmi_req_o, stack_save_o, stack_restore_o;
	logic [4:0] irq_id_o;
	logic [2:0] irq_prio_o;
	int mismatches = 0;
	int checked = 0;
	// source kinds: 0 set-pending, 1 soft trigger, 2 pulse, 3 level held
	nip_row_t rows [7] = '{'{5'd3, 1'b0, 2'd0, 1'b0},
		'{5'd7, 1'b1, 2'd1, 1'b0}, '{5'd12, 1'b1, 2'd2, 1'b0},
		'{5'd20, 1'b0, 2'd3, 1'b1}, '{5'd0, 1'b1, 2'd1, 1'b0},
		'{5'd0, 1'b1, 2'd2, 1'b0}, '{5'd0, 1'b0, 2'd3, 1'b1}};
	initial forever #50 ref_clk_i = ~ref_clk_i;
	nip_src src (.ref_clk_i(ref_clk_i), .irq_o(irq));
	nip_top DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .irq_i(irq),
		.nmi_i(nmi_i), .bus_i(bus), .core_i(core), .rdata_o(rdata_o),
		.irq_req_o(irq_req_o), .irq_id_o(irq_id_o), .irq_prio_o(irq_prio_o),
		.nmi_req_o(nmi_req_o), .stack_save_o(stack_save_o),
		.stack_restore_o(stack_restore_o));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i) bus <= {a, d, 2'b10};
		@(posedge ref_clk_i) bus <= '0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk_i) bus <= {a, 32'h0, 2'b01};
		@(posedge ref_clk_i) bus <= '0;
		#1 `CHK(rdata_o, e)
	endtask
	// entry or exit strobe, stack pulse looked at in its one cycle
	task automatic cev(input logic [2:0] k, input logic [4:0] id);
		@(posedge ref_clk_i) core <= {k[2:1], id, k[0]};
		@(posedge ref_clk_i) core <= '0;
		#1 `CHK(k[1] ? stack_restore_o : stack_save_o, 1'b1)
	endtask
	task automatic settle();
		repeat (5) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		mismatches++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		#1 `CHK({irq_req_o, nmi_req_o, stack_save_o, rdata_o}, 35'h0)
		rd(nip_pkg::OFS_ENABLE, nip_pkg::RST_ENABLE);
		rd(8'h30, 32'h0);
		$display("test reset done");
		wr(nip_pkg::OFS_ENABLE, 32'hffffffff);
		foreach (rows[i]) begin
			wr(nip_pkg::OFS_MODE, {31'h0, rows[i].md} << rows[i].id);
			case (rows[i].src)
				2'd0: wr(nip_pkg::OFS_SETPEND, 32'h1 << rows[i].id);
				2'd1: wr(nip_pkg::OFS_SOFT_TRIG, {27'h0, rows[i].id});
				2'd2: src.pulse(rows[i].id);
				default: src.hold(rows[i].id, 1'b1);
			endcase
			settle();
			`CHK({irq_req_o, irq_id_o}, {1'b1, rows[i].id})
			rd(nip_pkg::OFS_SETPEND, 32'h1 << rows[i].id);
			cev(3'b100, rows[i].id);
			rd(nip_pkg::OFS_ACTIVE, 32'h1 << rows[i].id);
			rd(nip_pkg::OFS_SETPEND, 32'h0);
			cev(3'b010, rows[i].id);
			settle();
			rd(nip_pkg::OFS_SETPEND, {31'h0, rows[i].ex} << rows[i].id);
			src.hold(rows[i].id, 1'b0);
			settle();
			wr(nip_pkg::OFS_CLRPEND, 32'hffffffff);
			$display("test row %0d done", i);
		end
		// pulse again during service, then clear only the pending part
		wr(nip_pkg::OFS_MODE, 32'h20);
		src.pulse(5);
		settle();
		cev(3'b100, 5'd5);
		src.pulse(5);
		settle();
		rd(nip_pkg::OFS_SETPEND, 32'h20);
		wr(nip_pkg::OFS_CLRPEND, 32'h20);
		rd(nip_pkg::OFS_SETPEND, 32'h0);
		rd(nip_pkg::OFS_ACTIVE, 32'h20);
		src.pulse(5);
		cev(3'b010, 5'd5);
		settle();
		rd(nip_pkg::OFS_SETPEND, 32'h20);
		wr(nip_pkg::OFS_CLRPEND, 32'h20);
		$display("test pulse in service done");
		// clear on a level line that is still high has no effect
		wr(nip_pkg::OFS_MODE, 32'h0);
		src.hold(6, 1'b1);
		settle();
		wr(nip_pkg::OFS_CLRPEND, 32'h40);
		settle();
		rd(nip_pkg::OFS_SETPEND, 32'h40);
		src.hold(6, 1'b0);
		settle();
		wr(nip_pkg::OFS_CLRPEND, 32'h40);
		rd(nip_pkg::OFS_SETPEND, 32'h0);
		$display("test level clear done");
		// equal priority picks the lower line, then reprioritise
		wr(nip_pkg::OFS_SETPEND, 32'h210);
		settle();
		`CHK(irq_id_o, 5'd4)
		rd(nip_pkg::OFS_STATUS, 32'h104);
		wr(nip_pkg::OFS_PRIO0, 32'h00050000);
		settle();
		`CHK({irq_id_o, irq_prio_o}, {5'd9, 3'd0})
		rd(nip_pkg::OFS_PRIO0, 32'h00050000);
		// line 4 in service at 5; split 3 puts 0 and 5 in one group
		cev(3'b100, 5'd4);
		settle();
		`CHK({irq_req_o, irq_id_o}, {1'b1, 5'd9})
		wr(nip_pkg::OFS_SPLIT, 32'h3);
		settle();
		`CHK(irq_req_o, 1'b0)
		rd(nip_pkg::OFS_SPLIT, 32'h3);
		wr(nip_pkg::OFS_SPLIT, 32'h0);
		cev(3'b010, 5'd4);
		wr(nip_pkg::OFS_CLRPEND, 32'hffffffff);
		$display("test priority done");
		// non-maskable input, enables all off
		wr(nip_pkg::OFS_ENABLE, 32'h0);
		nmi_i <= 1'b1;
		settle();
		`CHK(nmi_req_o, 1'b1)
		cev(3'b001, 5'd0);
		`CHK(nmi_req_o, 1'b0)
		$display("test nmi done");
		report_and_stop();
	end
endmodule
`default_nettype wire
